// *** core/tieoff_consts.vh ***
// Register offsets, field positions and reset values for the tie-off block
`ifndef TIEOFF_CONSTS_VH
`define TIEOFF_CONSTS_VH
`define ADDR_PWR1       8'h00
`define ADDR_PWR2       8'h04
`define ADDR_PWR3       8'h08
`define ADDR_OUTCTL     8'h0c
`define ADDR_INSW       8'h10
`define ADDR_STATUS     8'h14
`define ADDR_OVR        8'h18
`define PWR1_REFERENCE_IMPEDANCE_SELECT_LO  0
`define PWR1_REFERENCE_IMPEDANCE_SELECT_HI  1
`define PWR1_IOBUF      2
`define PWR1_ABIAS      3
`define PWR1_DCBUF      8
`define OUT_TIEOFF_IMP  1
`define OUT_SPK_BOOST   2
`define OUT_AUX2_BOOST  3
`define OUT_AUX1_BOOST  4
`define PWR2_LHP        7
`define PWR2_RHP        8
`define PWR3_RSPK       5
`define PWR3_LSPK       6
`define PWR3_AUX2       7
`define PWR3_AUX1       8
`define RST_REG9        9'h000
`define N_OUT           6
`define N_IN            4
`define IN_SW_W         4
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// *** core/tieoff_pin.v ***
// One analog pin tie-off selector
`timescale 1ns/10ps
module tieoff_pin (
   input  wire used_in,
   input  wire boosted_in,
   output wire tie_vref_out,
   output wire tie_boost_out
);
   // Switch follows used and boosted state only, not buffer enables
   assign tie_vref_out  = ~used_in & ~boosted_in;
   assign tie_boost_out = ~used_in & boosted_in;
endmodule // tieoff_pin

// *** core/tieoff_ctrl.v ***
// Codec power-management registers and automatic tie-off selection
//
// Function
// - Unused inputs to VREF, outputs by boost.
// - Output unused when its power enable clear.
// - Input unused when all its switches open.
// - Tie-off switches ignore buffer enable state.
// - Separate 1.0x and 1.5x buffer enables.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "tieoff_consts.vh"
module tieoff_ctrl (
   input  wire        core_clk_in,
   input  wire        arst_n_in,
   input  wire        clk_en_in,
   input  wire [7:0]  s_axi_awaddr_in,
   input  wire        s_axi_awvalid_in,
   output wire        s_axi_awready_out,
   input  wire [31:0] s_axi_wdata_in,
   input  wire [3:0]  s_axi_wstrb_in,
   input  wire        s_axi_wvalid_in,
   output wire        s_axi_wready_out,
   output reg  [1:0]  s_axi_bresp_out,
   output reg         s_axi_bvalid_out,
   input  wire        s_axi_bready_in,
   input  wire [7:0]  s_axi_araddr_in,
   input  wire        s_axi_arvalid_in,
   output wire        s_axi_arready_out,
   output reg  [31:0] s_axi_rdata_out,
   output reg  [1:0]  s_axi_rresp_out,
   output reg         s_axi_rvalid_out,
   input  wire        s_axi_rready_in,
   output reg  [5:0]  out_tie_vref_out,
   output reg  [5:0]  out_tie_boost_out,
   output reg  [3:0]  in_tie_vref_out,
   output reg         tieoff_buffer_enable_out,
   output reg         boosted_tieoff_buffer_enable_out,
   output reg  [1:0]  reference_impedance_select_out,
   output reg         analog_bias_enable_out,
   output reg         tieoff_low_imp_out
);
   // Register storage
   reg [8:0]  pwr1_reg;
   reg [8:0]  pwr2_reg;
   reg [8:0]  pwr3_reg;
   reg [8:0]  outctl_reg;
   reg [15:0] insw_reg;
   reg [9:0]  ovr_reg;
   // Write channel capture, address and data may arrive in either order
   reg        aw_have_reg;
   reg        w_have_reg;
   reg [7:0]  awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   reg        ar_busy_reg;

   wire [5:0]  out_used;
   wire [5:0]  out_boosted;
   wire [3:0]  in_used;
   wire [5:0]  o_vref;
   wire [5:0]  o_boost;
   wire [3:0]  i_vref;
   wire [3:0]  i_unused_b;
   wire        wr_go;
   wire [8:0]  wmask9;
   wire [15:0] wmask16;

   // Handshake readies are combinational; one write and one read at a time
   assign s_axi_awready_out = ~aw_have_reg & ~s_axi_bvalid_out;
   assign s_axi_wready_out  = ~w_have_reg & ~s_axi_bvalid_out;
   assign s_axi_arready_out = ~ar_busy_reg;
   assign wr_go   = aw_have_reg & w_have_reg & ~s_axi_bvalid_out;
   assign wmask9  = {wstrb_reg[1], {8{wstrb_reg[0]}}};
   assign wmask16 = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   // Output used flags: headphone L/R, speaker L/R, aux2, aux1
   assign out_used = {pwr3_reg[`PWR3_AUX1], pwr3_reg[`PWR3_AUX2],
                      pwr3_reg[`PWR3_RSPK], pwr3_reg[`PWR3_LSPK],
                      pwr2_reg[`PWR2_RHP],  pwr2_reg[`PWR2_LHP]};
   // Headphones never boost; speakers share one boost bit
   assign out_boosted = {outctl_reg[`OUT_AUX1_BOOST], outctl_reg[`OUT_AUX2_BOOST],
                         {2{outctl_reg[`OUT_SPK_BOOST]}}, 2'b00};

   // One pin selector per output and input; inputs never boost
   genvar gi;
   generate
      for (gi = 0; gi < `N_OUT; gi = gi + 1) begin : g_out
         tieoff_pin u_pin (
            .used_in       (out_used[gi]),
            .boosted_in    (out_boosted[gi]),
            .tie_vref_out  (o_vref[gi]),
            .tie_boost_out (o_boost[gi])
         );
      end
      for (gi = 0; gi < `N_IN; gi = gi + 1) begin : g_in
         // Input used when any switch onto it is closed
         assign in_used[gi] = |insw_reg[gi*`IN_SW_W +: `IN_SW_W];
         tieoff_pin u_pin (
            .used_in       (in_used[gi]),
            .boosted_in    (1'b0),
            .tie_vref_out  (i_vref[gi]),
            .tie_boost_out (i_unused_b[gi])
         );
      end
   endgenerate

   // Register writes and bus handshakes
   always @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwr1_reg         <= `RST_REG9;
         pwr2_reg         <= `RST_REG9;
         pwr3_reg         <= `RST_REG9;
         outctl_reg       <= `RST_REG9;
         insw_reg         <= 16'h0000;
         ovr_reg          <= 10'h000;
         aw_have_reg      <= 1'b0;
         w_have_reg       <= 1'b0;
         awaddr_reg       <= 8'h00;
         wdata_reg        <= 32'h0000_0000;
         wstrb_reg        <= 4'h0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= `RESP_OKAY;
      end else if (clk_en_in) begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_in;
            wstrb_reg  <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            aw_have_reg      <= 1'b0;
            w_have_reg       <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= `RESP_OKAY;
            case (awaddr_reg[7:2])
               // 1.0x and 1.5x buffer enables are separate bits
               6'd0: pwr1_reg   <= (pwr1_reg & ~wmask9) | (wdata_reg[8:0] & wmask9);
               6'd1: pwr2_reg   <= (pwr2_reg & ~wmask9) | (wdata_reg[8:0] & wmask9);
               6'd2: pwr3_reg   <= (pwr3_reg & ~wmask9) | (wdata_reg[8:0] & wmask9);
               6'd3: outctl_reg <= (outctl_reg & ~wmask9) | (wdata_reg[8:0] & wmask9);
               6'd4: insw_reg   <= (insw_reg & ~wmask16) | (wdata_reg[15:0] & wmask16);
               6'd5: ;  // Status is read only, write ignored
               6'd6: ovr_reg    <= {wstrb_reg[1] ? wdata_reg[9:8] : ovr_reg[9:8],
                                    wstrb_reg[0] ? wdata_reg[7:0] : ovr_reg[7:0]};
               default: s_axi_bresp_out <= `RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Read channel, one cycle answer from the address
   always @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ar_busy_reg      <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= 32'h0000_0000;
         s_axi_rresp_out  <= `RESP_OKAY;
      end else if (clk_en_in) begin
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            ar_busy_reg      <= 1'b1;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= `RESP_OKAY;
            case (s_axi_araddr_in[7:2])
               6'd0: s_axi_rdata_out <= {23'h000000, pwr1_reg};
               6'd1: s_axi_rdata_out <= {23'h000000, pwr2_reg};
               6'd2: s_axi_rdata_out <= {23'h000000, pwr3_reg};
               6'd3: s_axi_rdata_out <= {23'h000000, outctl_reg};
               6'd4: s_axi_rdata_out <= {16'h0000, insw_reg};
               // Live used flags so software can see the automatic decision
               6'd5: s_axi_rdata_out <= {14'h0000, out_boosted, 2'b00, out_used, in_used};
               6'd6: s_axi_rdata_out <= {22'h000000, ovr_reg};
               default: begin
                  s_axi_rdata_out <= 32'h0000_0000;
                  s_axi_rresp_out <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            ar_busy_reg      <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // Tie-off switch outputs, registered; manual overrides force a pin to tie-off.
   // Detection runs every enabled cycle regardless of buffer state.
   always @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         out_tie_vref_out                 <= 6'h00;
         out_tie_boost_out                <= 6'h00;
         in_tie_vref_out                  <= 4'h0;
         tieoff_buffer_enable_out         <= 1'b0;
         boosted_tieoff_buffer_enable_out <= 1'b0;
         reference_impedance_select_out   <= 2'b00;
         analog_bias_enable_out           <= 1'b0;
         tieoff_low_imp_out               <= 1'b0;
      end else if (clk_en_in) begin
         out_tie_vref_out  <= o_vref | (ovr_reg[5:0] & ~out_boosted);
         out_tie_boost_out <= o_boost | (ovr_reg[5:0] & out_boosted);
         in_tie_vref_out   <= i_vref | ovr_reg[9:6];
         tieoff_buffer_enable_out         <= pwr1_reg[`PWR1_IOBUF];
         boosted_tieoff_buffer_enable_out <= pwr1_reg[`PWR1_DCBUF];
         reference_impedance_select_out   <= pwr1_reg[`PWR1_REFERENCE_IMPEDANCE_SELECT_HI:`PWR1_REFERENCE_IMPEDANCE_SELECT_LO];
         analog_bias_enable_out           <= pwr1_reg[`PWR1_ABIAS];
         tieoff_low_imp_out               <= outctl_reg[`OUT_TIEOFF_IMP];
      end
   end
endmodule // tieoff_ctrl

// *** test/tieoff_ctrl_sva.sv ***
// Port assertions for the tie-off block
`timescale 1ns/10ps
module tieoff_ctrl_sva (
   input logic        core_clk_in,
   input logic        arst_n_in,
   input logic        clk_en_in,
   input logic [7:0]  s_axi_awaddr_in,
   input logic        s_axi_awvalid_in,
   input logic        s_axi_awready_out,
   input logic [31:0] s_axi_wdata_in,
   input logic        s_axi_wvalid_in,
   input logic        s_axi_wready_out,
   input logic        s_axi_bvalid_out,
   input logic        s_axi_bready_in,
   input logic [1:0]  s_axi_bresp_out,
   input logic [5:0]  out_tie_vref_out,
   input logic [5:0]  out_tie_boost_out,
   input logic        tieoff_buffer_enable_out,
   input logic        boosted_tieoff_buffer_enable_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   logic [1:0] wbit_reg;
   // Both halves of a PWR1 write taken at one edge
   wire pwr1_take = clk_en_in & s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in
                    & s_axi_wready_out & (s_axi_awaddr_in == 8'h00);
   // Buffer bits of the last PWR1 word, so the copy can be judged later
   always @(posedge core_clk_in or negedge arst_n_in)
      if (!arst_n_in)
         wbit_reg <= 2'b00;
      else if (pwr1_take)
         wbit_reg <= {s_axi_wdata_in[8], s_axi_wdata_in[2]};
   sequence pwr1_wr;
      pwr1_take;
   endsequence
   a_tie_excl: assert property ((out_tie_vref_out & out_tie_boost_out) == 6'h00)
      else $error("Output tied to both sources");
   a_hp_noboost: assert property (out_tie_boost_out[1:0] == 2'b00)
      else $error("Headphone tied to boosted source");
   a_reset_unused: assert property ($rose(arst_n_in) |-> ##[1:2] out_tie_vref_out == 6'h3f)
      else $error("Outputs not tied after reset");
   a_buf_indep: assert property (pwr1_wr |=> $stable(out_tie_vref_out) [*3])
      else $error("Buffer write moved a tie-off switch");
   a_buf_copy: assert property (pwr1_wr |-> ##3 {boosted_tieoff_buffer_enable_out,
      tieoff_buffer_enable_out} == wbit_reg) else $error("Buffer enable not applied");
   a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("Write answer dropped");
endmodule // tieoff_ctrl_sva
bind tieoff_ctrl tieoff_ctrl_sva i_sva (.*);

// *** test/codec_host.sv ***
// Behavioural host driving the codec register bus
`timescale 1ns/10ps
module codec_host (
   input  logic        clk_in,
   input  logic        awready_in,
   input  logic        wready_in,
   input  logic        bvalid_in,
   input  logic        arready_in,
   input  logic        rvalid_in,
   output logic [7:0]  addr_out,
   output logic [31:0] wdata_out,
   output logic        awvalid_out,
   output logic        wvalid_out,
   output logic        bready_out,
   output logic        arvalid_out,
   output logic        rready_out
);
   integer tmo = 0; // Counts waits that ran out
   initial {addr_out, wdata_out, awvalid_out, wvalid_out, bready_out, arvalid_out,
            rready_out} = 45'h0;
   // One write finishes before the next step starts
   task wr(input logic [7:0] a, input logic [31:0] d);
      integer n;
      begin
         @(posedge clk_in);
         addr_out <= a;
         wdata_out <= d;
         {awvalid_out, wvalid_out, bready_out} <= 3'h7;
         n = 0;
         do begin
            @(posedge clk_in);
            n++;
            if (awready_in) awvalid_out <= 1'b0;
            if (wready_in) wvalid_out <= 1'b0;
         end while (!bvalid_in && n < 50);
         bready_out <= 1'b0;
         tmo += (n >= 50);
      end
   endtask
   // Read; the answer is judged by the bench monitor
   task rd(input logic [7:0] a);
      integer n;
      begin
         @(posedge clk_in);
         addr_out <= a;
         {arvalid_out, rready_out} <= 2'h3;
         n = 0;
         do begin
            @(posedge clk_in);
            n++;
            if (arready_in) arvalid_out <= 1'b0;
         end while (!rvalid_in && n < 50);
         rready_out <= 1'b0;
         tmo += (n >= 50);
      end
   endtask
endmodule // codec_host

// *** test/codec_powerup_tieoff_sequencer_tb_top.sv ***
// Self-checking bench for the tie-off block
`timescale 1ns/10ps
module codec_powerup_tieoff_sequencer_tb_top;
   localparam int SETTLE = 20; // Shortened charge wait
   logic        core_clk_in = 1'b0, arst_n_in = 1'b0, clk_en_in = 1'b1;
   logic [3:0]  s_axi_wstrb_in = 4'hf;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, p2, p3, oc, sw;
   logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
   logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic        s_axi_rvalid_out, s_axi_rready_in, tieoff_low_imp_out;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, reference_impedance_select_out;
   logic [5:0]  out_tie_vref_out, out_tie_boost_out, used, bst;
   logic [3:0]  in_tie_vref_out, inu;
   logic        tieoff_buffer_enable_out, boosted_tieoff_buffer_enable_out;
   logic        analog_bias_enable_out;
   logic [8:0]  pw [2] = '{9'h104, 9'h10d};
   logic [19:0] exp_q[$]; // Expected {resp, status bits} per read
   integer      fail_count = 0, num_checks = 0, seed = 32'h57de, i, k;
   assign s_axi_araddr_in = s_axi_awaddr_in;
   tieoff_ctrl i_tieoff_ctrl (.*);
   codec_host host (.clk_in(core_clk_in), .awready_in(s_axi_awready_out),
      .wready_in(s_axi_wready_out), .bvalid_in(s_axi_bvalid_out), .addr_out(s_axi_awaddr_in),
      .arready_in(s_axi_arready_out), .rvalid_in(s_axi_rvalid_out), .wdata_out(s_axi_wdata_in),
      .awvalid_out(s_axi_awvalid_in), .wvalid_out(s_axi_wvalid_in), .bready_out(s_axi_bready_in),
      .arvalid_out(s_axi_arvalid_in), .rready_out(s_axi_rready_in));
   initial forever #5 core_clk_in = ~core_clk_in;
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run;
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Every accepted read answer meets the oldest note
   always @(posedge core_clk_in)
      if (s_axi_rvalid_out && s_axi_rready_in)
         cmp({s_axi_rresp_out, s_axi_rdata_out[17:0]}, exp_q.pop_front());
   initial begin
      repeat (6) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      cmp({in_tie_vref_out, out_tie_vref_out, out_tie_boost_out}, 16'hffc0);
      host.wr(8'h0c, 32'h0);
      for (i = 0; i < 2; i++) begin
         host.wr(8'h00, {23'h0, pw[i]});
         repeat (3) @(posedge core_clk_in);
         cmp({boosted_tieoff_buffer_enable_out, tieoff_buffer_enable_out, analog_bias_enable_out,
              reference_impedance_select_out}, {pw[i][8], pw[i][2], pw[i][3], pw[i][1:0]});
      end
      repeat (SETTLE) @(posedge core_clk_in);
      // Random path enables, boosts and switches; sparse switches leave inputs unused
      for (i = 0; i < 24; i++) begin
         p2 = $random(seed);
         p3 = $random(seed);
         oc = $random(seed) & 32'h1e;
         sw = $random(seed) & $random(seed) & $random(seed) & 32'hffff;
         host.wr(8'h04, p2);
         host.wr(8'h08, p3);
         host.wr(8'h0c, oc);
         host.wr(8'h10, sw);
         repeat (3) @(posedge core_clk_in);
         used = {p3[8], p3[7], p3[5], p3[6], p2[8], p2[7]};
         bst = {oc[4], oc[3], {2{oc[2]}}, 2'b00};
         for (k = 0; k < 4; k++) inu[k] = |sw[4*k +: 4];
         cmp({out_tie_vref_out, out_tie_boost_out}, {~used & ~bst, ~used & bst});
         cmp({in_tie_vref_out, tieoff_low_imp_out}, {~inu, oc[1]});
         exp_q.push_back({2'b00, bst, 2'b00, used, inu});
         host.rd(8'h14);
      end
      exp_q.push_back(20'h80000);
      host.rd(8'h1c);
      repeat (3) @(posedge core_clk_in);
      // Mid-run reset must return every pin to the unused tie-off
      arst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      cmp({in_tie_vref_out, out_tie_vref_out, out_tie_boost_out}, 16'hffc0);
      fail_count += host.tmo;
      complete_run();
   end
endmodule // codec_powerup_tieoff_sequencer_tb_top
